// *** omb_regs.vh ***
// register offsets, field positions, reset values and timing for the mode and bus block
`ifndef OMB_REGS_VH
`define OMB_REGS_VH
`define OMB_ADDR_W 4
`define OMB_OFF_MODE 4'h0
`define OMB_OFF_PORTE_ASSIGN 4'h1
`define OMB_OFF_EXT_BUS_CTRL 4'h2
`define OMB_OFF_STATUS 4'h3
`define OMB_MODE_INTERNAL_VISIBILITY_BIT 3
`define OMB_MODE_LO_BIT 5
`define OMB_MODE_HI_BIT 7
`define OMB_PEA_BUS_CLOCK_DISABLE_BIT 4
`define OMB_PEA_PIPE_OUT_ENABLE_BIT 5
`define OMB_PEA_LOW_STROBE_ENABLE_BIT 3
`define OMB_PEA_READ_WRITE_PIN_ENABLE_BIT 2
`define OMB_EBC_BUS_CLOCK_STRETCH_BIT_BIT 0
`define OMB_MODE_SS 3'h0
`define OMB_MODE_EMU_NAR 3'h1
`define OMB_MODE_EMU_WIDE 3'h3
`define OMB_MODE_NS 3'h4
`define OMB_MODE_NORM_NAR 3'h5
`define OMB_MODE_NORM_WIDE 3'h7
`define OMB_PEA_RST_SINGLE 8'h00
`define OMB_PEA_RST_EXP 8'h00
`define OMB_EBC_RST 8'h01
`define OMB_BUS_CLOCK_OUT_DIV 2
`endif

// *** omb_bus_clock_out_gen.v ***
// bus clock generator with optional stretch for port e bit 4
`timescale 1ns/1ps
`default_nettype none
module omb_bus_clock_out_gen #(
	parameter DIV = 2
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire stretch_i,
	output reg bus_clock_out_o
);
	// divider held at the counter width so the limit arithmetic stays four bits
	localparam [3:0] DIV_W = DIV;
	reg [3:0] cnt_q;
	wire [3:0] lim;
	// stretch doubles the high/low phase length for slow memories
	assign lim = stretch_i ? {DIV_W[2:0], 1'b0} - 4'h1 : DIV_W - 4'h1;
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			bus_clock_out_o <= 1'b0;
		end else if (cnt_q >= lim) begin
			cnt_q <= 4'h0;
			bus_clock_out_o <= ~bus_clock_out_o;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** omb_mode_bus_cfg.v ***
// operating mode latch and external bus pin configuration
// What this block does
// - mode pins latched at reset release, readable
// - mode field uses documented three bit encoding
// - middle high, low low means reserved test
// - debug active after reset only special single
// - normal modes protect bus control bits from writes, and mode bits too except one write in normal single chip
// - port e bit 1 plain pulled-up input
// - port e bit 0 plain pulled-up input
// - reset sets clock stretch bit in every mode
// - mode/pipe pins pulled down during reset only
// - normal single chip: no bus, pulldowns
// - single chip blocks pipe, strobe, rw functions
// - normal single chip allows one mode write
// - single chip: clear disable drives free clock
// - wide modes: ports a/b form 16-bit bus
// - normal wide: port e gpio until enabled, except bit 4 clock
// - pipe enable drives pipe status bits 6,5
// - rw enable turns bit 2 into rw
// - strobe enable turns bit 3 into strobe except in normal narrow
// - bit 4 clock depends on four bits
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "omb_regs.vh"
module omb_mode_bus_cfg #(
	parameter BUS_CLOCK_OUT_DIV = `OMB_BUS_CLOCK_OUT_DIV
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire mode_select_hi_i,
	input wire mode_select_mid_i,
	input wire mode_select_lo_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire bdm_serial_activate_i,
	input wire [1:0] pipe_status_i,
	input wire low_byte_strobe_i,
	input wire bus_rw_i,
	output wire debug_active_o,
	output wire special_mode_o,
	output wire factory_test_o,
	output wire ab_bus_en_o,
	output wire ab_wide_o,
	output wire [7:0] porte_alt_en_o,
	output wire [7:0] porte_alt_out_o,
	output wire [7:0] porte_pullup_o,
	output wire [7:0] porte_pulldown_o,
	output wire ab_pulldown_o,
	output wire porte_bit4_drive_o
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	reg [2:0] mode_s1_q;
	reg [2:0] mode_s2_q;
	always @(posedge sys_clk_i) begin
		mode_s1_q <= {mode_select_hi_i, mode_select_mid_i, mode_select_lo_i};
		mode_s2_q <= mode_s1_q;
	end
	reg act_s1_q;
	reg act_s2_q;
	always @(posedge sys_clk_i) begin
		act_s1_q <= bdm_serial_activate_i;
		act_s2_q <= act_s1_q;
	end
	////////////////////////////////////////////////////////////////////////////
	// mode latch state
	reg rst_d1_q;
	reg [2:0] mode_q;
	reg [2:0] mode_d;
	reg internal_visibility_q;
	reg internal_visibility_d;
	reg mode_wr_used_q;
	reg [7:0] pea_q;
	reg [7:0] pea_d;
	reg bus_clock_stretch_bit_q;
	reg bdm_act_q;
	wire rel_edge;
	wire special;
	wire single;
	wire wide;
	wire expanded;
	wire mode_wr;
	wire pea_wr;
	wire ebc_wr;
	wire mode_wr_ok;
	wire [7:0] ebc_rst;
	// reset image of the external bus control register
	assign ebc_rst = `OMB_EBC_RST;
	// falling edge of reset, the reset release
	always @(posedge sys_clk_i) begin
		rst_d1_q <= rst_i;
	end
	assign rel_edge = rst_d1_q & ~rst_i;
	assign special = ~mode_q[2];
	assign single = ~mode_q[0];
	assign wide = mode_q[0] & mode_q[1];
	assign expanded = mode_q[0];
	assign mode_wr = wr_i & (addr_i == `OMB_OFF_MODE);
	assign pea_wr = wr_i & (addr_i == `OMB_OFF_PORTE_ASSIGN);
	assign ebc_wr = wr_i & (addr_i == `OMB_OFF_EXT_BUS_CTRL);
	// special modes write freely, normal single chip once, others never
	assign mode_wr_ok = special | ((mode_q == `OMB_MODE_NS) & ~mode_wr_used_q);
	////////////////////////////////////////////////////////////////////////////
	// mode field update
	always @* begin
		mode_d = mode_q;
		internal_visibility_d = internal_visibility_q;
		if (rel_edge) begin
			mode_d = mode_s2_q;
			internal_visibility_d = 1'b0;
		end else if (mode_wr && mode_wr_ok) begin
			// a write never reaches a reserved test encoding
			if (!(wdata_i[`OMB_MODE_LO_BIT+1] && !wdata_i[`OMB_MODE_LO_BIT])) begin
				mode_d = wdata_i[`OMB_MODE_HI_BIT:`OMB_MODE_LO_BIT];
			end
			internal_visibility_d = wdata_i[`OMB_MODE_INTERNAL_VISIBILITY_BIT];
		end // otherwise held
	end
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode_q <= `OMB_MODE_SS;
			internal_visibility_q <= 1'b0;
			mode_wr_used_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			internal_visibility_q <= internal_visibility_d;
			if (mode_wr && !rel_edge) begin
				mode_wr_used_q <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// port e assignment and external bus control registers
	always @* begin
		pea_d = pea_q;
		if (rel_edge) begin
			// mode_q is not yet updated here, so look at the latched pins
			pea_d = mode_s2_q[0] ? `OMB_PEA_RST_EXP : `OMB_PEA_RST_SINGLE;
		end else if (pea_wr) begin
			pea_d = wdata_i;
		end
	end
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			pea_q <= `OMB_PEA_RST_SINGLE;
			bus_clock_stretch_bit_q <= 1'b1;
			bdm_act_q <= 1'b0;
		end else begin
			pea_q <= pea_d;
			if (rel_edge) begin
				bus_clock_stretch_bit_q <= ebc_rst[`OMB_EBC_BUS_CLOCK_STRETCH_BIT_BIT];
			end else if (ebc_wr && special) begin
				bus_clock_stretch_bit_q <= wdata_i[`OMB_EBC_BUS_CLOCK_STRETCH_BIT_BIT];
			end
			// debug runs at once in special single chip, else by command
			if (rel_edge) begin
				bdm_act_q <= (mode_s2_q == `OMB_MODE_SS);
			end else if (act_s2_q) begin
				bdm_act_q <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// register read port, one cycle latency
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
			`OMB_OFF_MODE: rdata_o <= {mode_q, 1'b0, internal_visibility_q, 3'h0};
			`OMB_OFF_PORTE_ASSIGN: rdata_o <= pea_q;
			`OMB_OFF_EXT_BUS_CTRL: rdata_o <= {7'h00, bus_clock_stretch_bit_q};
			`OMB_OFF_STATUS: rdata_o <= {5'h00, mode_wr_used_q, factory_test_o, bdm_act_q};
			default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// bus clock generator on port e bit 4
	wire bus_clock_out;
	omb_bus_clock_out_gen #(
		.DIV(BUS_CLOCK_OUT_DIV)
	) u_bus_clock_out (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.stretch_i(bus_clock_stretch_bit_q),
		.bus_clock_out_o(bus_clock_out)
	);
	////////////////////////////////////////////////////////////////////////////
	// port e pin functions
	wire pipo_en;
	wire lstr_en;
	wire rdw_en;
	wire bus_clock_out_on;
	assign pipo_en = ~single & pea_q[`OMB_PEA_PIPE_OUT_ENABLE_BIT];
	// strobe is never available in normal expanded narrow
	assign lstr_en = ~single & pea_q[`OMB_PEA_LOW_STROBE_ENABLE_BIT] & (wide | special);
	assign rdw_en = ~single & pea_q[`OMB_PEA_READ_WRITE_PIN_ENABLE_BIT];
	// clock output: on unless disabled; in wide modes visibility keeps it on
	assign bus_clock_out_on = ~pea_q[`OMB_PEA_BUS_CLOCK_DISABLE_BIT] | (wide & internal_visibility_q);
	assign porte_alt_en_o = rst_i ? 8'h00 : {1'b0, pipo_en, pipo_en, bus_clock_out_on, lstr_en,
		rdw_en, 2'h0};
	assign porte_alt_out_o = {1'b0, pipe_status_i, bus_clock_out & bus_clock_out_on, low_byte_strobe_i,
		bus_rw_i, 2'h0};
	assign porte_bit4_drive_o = ~rst_i & bus_clock_out_on;
	assign porte_pullup_o = 8'h03;
	// bits 6,5 pulled down only while reset holds; bits 7,4,3,2 gpio pulldowns
	assign porte_pulldown_o = rst_i ? 8'h60 : (8'hFC & ~8'h60 & ~porte_alt_en_o);
	////////////////////////////////////////////////////////////////////////////
	// mode status outputs
	assign ab_bus_en_o = ~rst_i & expanded;
	assign ab_wide_o = ~rst_i & wide;
	assign ab_pulldown_o = rst_i | single;
	assign debug_active_o = bdm_act_q;
	assign special_mode_o = special;
	assign factory_test_o = mode_q[1] & ~mode_q[0];
endmodule
`default_nettype wire

// *** omb_mode_bus_cfg_asserts.sv ***
// concurrent checks on the mode and bus configuration ports
`timescale 1ns/1ps
`default_nettype none
module omb_mode_bus_cfg_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic debug_active_o,
	input wire logic factory_test_o,
	input wire logic ab_bus_en_o,
	input wire logic ab_wide_o,
	input wire logic [7:0] porte_alt_en_o,
	input wire logic [7:0] porte_pullup_o,
	input wire logic [7:0] porte_pulldown_o,
	input wire logic ab_pulldown_o
);
	default clocking dc @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// read data, pulls, gating and mode hold
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not idle");
	a_pullup_fixed: assert property (porte_pullup_o == 8'h03)
		else $error("pull-ups wrong");
	a_reset_pulldown: assert property (disable iff (1'b0) rst_i && $past(rst_i) |-> porte_pulldown_o == 8'h60)
		else $error("reset pull-downs wrong");
	a_run_pulldown: assert property (!$past(rst_i) |-> porte_pulldown_o[6:5] == 2'b00)
		else $error("select pins still pulled");
	a_single_gate: assert property (!ab_bus_en_o |-> (porte_alt_en_o & 8'h6C) == 8'h00)
		else $error("alt function in single chip");
	a_ab_pulls: assert property ((ab_pulldown_o == !ab_bus_en_o) && (!ab_wide_o || ab_bus_en_o))
		else $error("port a b setup wrong");
	a_mode_hold: assert property (!$past(wr_i) && !$past(wr_i, 2) && !$past(rst_i, 2) |-> $stable({ab_bus_en_o, ab_wide_o, factory_test_o}))
		else $error("mode changed without write");
	a_debug_sticky: assert property (debug_active_o |=> debug_active_o)
		else $error("debug dropped");
endmodule
bind omb_mode_bus_cfg omb_mode_bus_cfg_asserts u_chk (.sys_clk_i, .rst_i, .wr_i, .rd_i, .rdata_o,
	.debug_active_o, .factory_test_o, .ab_bus_en_o, .ab_wide_o, .porte_alt_en_o,
	.porte_pullup_o, .porte_pulldown_o, .ab_pulldown_o);
`default_nettype wire

// *** omb_ext_bus_model.sv ***
// external bus device that counts bus clock edges on port e bit 4
`timescale 1ns/1ps
`default_nettype none
module omb_ext_bus_model (
	input wire logic sys_clk_i,
	input wire logic bus_clock_out_i,
	input wire logic bus_clock_out_en_i,
	output var int edges_o
);
	logic last_q;
	////////////////////////////////////////
	// count rising edges only while the pin is driven
	always @(posedge sys_clk_i) begin
		last_q <= bus_clock_out_i;
		if (bus_clock_out_en_i && bus_clock_out_i && !last_q) begin
			edges_o <= edges_o + 1;
		end
	end
endmodule
`default_nettype wire

// *** tb_omb_mode_bus_cfg.sv ***
// self-checking bench for the mode and bus configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_omb_mode_bus_cfg;
	logic sys_clk_i, rst_i, wr_i, rd_i, bdm_serial_activate_i, low_byte_strobe_i, bus_rw_i;
	logic mode_select_hi_i, mode_select_mid_i, mode_select_lo_i, debug_active_o, special_mode_o;
	logic factory_test_o, ab_bus_en_o, ab_wide_o, ab_pulldown_o, porte_bit4_drive_o;
	logic [3:0] addr_i;
	logic [1:0] pipe_status_i;
	logic [7:0] wdata_i, rdata_o, porte_alt_en_o, porte_alt_out_o, porte_pullup_o, porte_pulldown_o;
	int err_total, check_count, cyc, edges;
	omb_mode_bus_cfg #(.BUS_CLOCK_OUT_DIV(1)) dut (.sys_clk_i, .rst_i, .mode_select_hi_i,
		.mode_select_mid_i, .mode_select_lo_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.bdm_serial_activate_i, .pipe_status_i, .low_byte_strobe_i, .bus_rw_i,
		.debug_active_o, .special_mode_o, .factory_test_o, .ab_bus_en_o, .ab_wide_o,
		.porte_alt_en_o, .porte_alt_out_o, .porte_pullup_o, .porte_pulldown_o,
		.ab_pulldown_o, .porte_bit4_drive_o);
	omb_ext_bus_model u_ext (.sys_clk_i, .bus_clock_out_i(porte_alt_out_o[4]),
		.bus_clock_out_en_i(porte_bit4_drive_o), .edges_o(edges));
	////////////////////////////////////////
	// shared bus and compare tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task automatic boot(input logic [2:0] m);
		@(posedge sys_clk_i);
		{mode_select_hi_i, mode_select_mid_i, mode_select_lo_i} <= m;
		rst_i <= 1'b1;
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	// every pin setting out of reset
	task automatic t_modes();
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			m = i[2:0];
			boot(m);
			chk(factory_test_o, m[1] & !m[0]);
			if (!(m[1] & !m[0])) begin
				rd(4'h0, {m, 5'h00});
				rd(4'h2, 8'h01);
				chk({debug_active_o, special_mode_o}, {m == 3'h0, !m[2]});
				chk({ab_bus_en_o, ab_wide_o, ab_pulldown_o}, {m[0], m[1] & m[0], !m[0]});
				chk(porte_pullup_o, 8'h03);
				if (m[2]) chk(porte_alt_en_o & 8'h6C, 8'h00);
			end
		end
	endtask
	// one mode write in normal single chip, then bus control pins
	task automatic t_single();
		boot(3'h4);
		wr(4'h1, 8'h6C);
		chk(porte_alt_en_o & 8'h6C, 8'h00);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h01);
		wr(4'h0, 8'hE8);
		wr(4'h0, 8'h80);
		rd(4'h0, 8'hE8);
		rd(4'h3, 8'h04);
		@(posedge sys_clk_i);
		pipe_status_i <= 2'h2;
		low_byte_strobe_i <= 1'b1;
		#1 chk(porte_alt_en_o & 8'h6C, 8'h6C);
		chk(porte_alt_out_o & 8'h6C, 8'h48);
	endtask
	// special single chip: wider access and free-running bus clock
	task automatic t_special();
		int e0;
		boot(3'h0);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h00);
		e0 = edges;
		repeat (40) @(posedge sys_clk_i);
		#1 chk({porte_bit4_drive_o, edges - e0 > 4}, 8'h03);
		wr(4'h1, 8'h10);
		chk(porte_bit4_drive_o, 1'b0);
	endtask
	// serial activation of debug in a normal mode, refused writes
	task automatic t_debug();
		boot(3'h5);
		chk(debug_active_o, 1'b0);
		@(posedge sys_clk_i);
		bdm_serial_activate_i <= 1'b1;
		for (int k = 0; k < 8 && debug_active_o !== 1'b1; k++) @(posedge sys_clk_i);
		#1 chk(debug_active_o, 1'b1);
		wr(4'h0, 8'hE0);
		rd(4'h0, 8'hA0);
		rd(4'hF, 8'h00);
	endtask
	task automatic summarize();
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// clock, hang limit and main sequence
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		{rst_i, wr_i, rd_i, bdm_serial_activate_i, low_byte_strobe_i, bus_rw_i} = 6'h20;
		{mode_select_hi_i, mode_select_mid_i, mode_select_lo_i, addr_i, pipe_status_i} = 9'h000;
		wdata_i = 8'h00;
		t_modes();
		t_single();
		t_special();
		t_debug();
		summarize();
	end
endmodule
`default_nettype wire
